/* include/scb_map.svh */
// Register offsets, bit positions, reset values and bus timing counts
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

// --------------------------------------------------
// Register offsets
// --------------------------------------------------
`define SCB_OFF_ACC   8'h00
`define SCB_OFF_EXT   8'h04
`define SCB_OFF_STAT  8'h08
`define SCB_OFF_CMD   8'h0C
`define SCB_OFF_BUS   8'h10
`define SCB_OFF_INSN  8'h14

// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define SCB_ST_IE     3
`define SCB_ST_SA     4
`define SCB_ST_SB     5
`define SCB_BS_BUSY   0
`define SCB_BS_IRQ    1
`define SCB_BS_SOUT   2
`define SCB_BS_DMA    3
`define SCB_DB_RD     4
`define SCB_DB_FETCH  5
`define SCB_DB_DELAY  6
`define SCB_DB_HALT   7

// --------------------------------------------------
// Reset values and timing counts
// --------------------------------------------------
`define SCB_RST_BYTE  8'h00
`define SCB_RST_PTR   16'h0000
`define SCB_RST_ADDR  12'h000
`define SCB_RST_NIB   4'h0
`define SCB_RST_CNT   2'h0
`define SCB_CNT_ONE   2'h1
`define SCB_PC_STEP   12'h001
`define SCB_ADS_LAST  2'h1
`define SCB_STB_LAST  2'h2

`endif

/* include/scb_pkg.sv */
// Types shared by the bus and I/O unit
package scb_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_STRB, ST_DMA} scb_state_t;
    typedef enum logic [3:0] {
        OP_NOP, OP_LOAD, OP_STORE, OP_FETCH, OP_SHIFT, OP_XAE, OP_CSA, OP_CAS,
        OP_XPAL, OP_XPAH, OP_ADD, OP_AND, OP_OR, OP_XOR, OP_HALT, OP_DELAY
    } scb_op_t;
endpackage

/* src/scb_ptr_reg.sv */
// One 16-bit pointer register with byte loads and in-page increment
`timescale 1ns/1ps
`default_nettype none
`include "scb_map.svh"
module scb_ptr_reg (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Control
    input  wire logic        load_lo_i,
    input  wire logic        load_hi_i,
    input  wire logic        inc_i,
    input  wire logic [7:0]  byte_i,
    // Value
    output logic      [15:0] ptr_o
);
    // Increment wraps inside the 4K page
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
            ptr_o <= `SCB_RST_PTR;
        else if (inc_i)
            ptr_o[11:0] <= ptr_o[11:0] + `SCB_PC_STEP;
        else if (load_lo_i)
            ptr_o[7:0] <= byte_i;
        else if (load_hi_i)
            ptr_o[15:8] <= byte_i;
    end
endmodule // scb_ptr_reg
`default_nettype wire

/* src/scb_bus_io.sv */
// External bus, sense, flag and serial unit of the 8-bit processor
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scb_map.svh"
module scb_bus_io
    import scb_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // External bus
    output logic      [11:0] addr_o,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    output logic             read_strobe_n_o,
    output logic             write_strobe_n_o,
    output logic             address_strobe_n_o,
    // DMA
    input  wire logic        dma_req_i,
    output logic             dma_grant_o,
    // Sense, serial and flags
    input  wire logic        sense_a_i,
    input  wire logic        sense_b_i,
    input  wire logic        serial_in_pin_i,
    output logic             serial_out_o,
    output logic      [2:0]  flag_o,
    output logic             irq_taken_o
);
    scb_state_t  state_reg;
    logic [1:0]  cnt_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  ext_reg;
    logic [7:0]  status_reg;
    logic [7:0]  insn_reg;
    logic        sout_reg;
    logic        irq_seen_reg;
    logic        irq_pulse_reg;
    logic        cyc_rd_reg;
    logic        cyc_wr_reg;
    logic        cyc_fetch_reg;
    logic        cyc_mark_reg;
    logic [3:0]  addr_hi_reg;
    logic [15:0] ptr_q [4];
    logic [15:0] sel_ptr;
    logic [15:0] bus_addr;
    logic [7:0]  status_rd;
    logic [7:0]  ads_byte;
    logic [7:0]  status_wr;
    scb_op_t     cmd_op;
    logic [1:0]  cmd_sel;
    logic        cmd_go;
    logic        irq_div;
    logic        bus_start;
    logic        rd_done;
    logic        wr_acc;
    logic        wr_ext;
    logic        wr_stat;
    logic        wr_bus;

    // --------------------------------------------------
    // Command decode
    // --------------------------------------------------
    assign cmd_op  = scb_op_t'(reg_wdata_i[3:0]);
    assign cmd_sel = reg_wdata_i[5:4];
    assign wr_acc  = reg_wr_i && (reg_addr_i == `SCB_OFF_ACC);
    assign wr_ext  = reg_wr_i && (reg_addr_i == `SCB_OFF_EXT);
    assign wr_stat = reg_wr_i && (reg_addr_i == `SCB_OFF_STAT);
    assign wr_bus  = reg_wr_i && (reg_addr_i == `SCB_OFF_BUS);
    // Commands are taken only while idle and no DMA request is pending
    assign cmd_go  = reg_wr_i && (reg_addr_i == `SCB_OFF_CMD)
                     && (state_reg == ST_IDLE) && !dma_req_i;
    // Enabled fetch samples sense A and is diverted when it is high
    assign irq_div = cmd_go && (cmd_op == OP_FETCH)
                     && status_reg[`SCB_ST_IE] && sense_a_i;
    assign bus_start = cmd_go && !irq_div
                       && (cmd_op inside {OP_LOAD, OP_STORE, OP_FETCH, OP_HALT, OP_DELAY});
    assign rd_done = (state_reg == ST_STRB) && (cnt_reg == `SCB_STB_LAST) && cyc_rd_reg;

    // Sense levels appear live in the status byte
    always_comb
    begin
        status_rd = status_reg;
        status_rd[`SCB_ST_SA] = sense_a_i;
        status_rd[`SCB_ST_SB] = sense_b_i;
    end

    // Sense bit positions are not stored
    always_comb
    begin
        status_wr = (wr_stat) ? reg_wdata_i : acc_reg;
        status_wr[`SCB_ST_SA] = 1'b0;
        status_wr[`SCB_ST_SB] = 1'b0;
    end

    // --------------------------------------------------
    // Pointer registers, pointer 0 is the program counter
    // --------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ptr
            scb_ptr_reg u_ptr (
                .mclk_i    (mclk_i),
                .sys_rst_i (sys_rst_i),
                .load_lo_i (cmd_go && (cmd_op == OP_XPAL) && (cmd_sel == gi)),
                .load_hi_i (cmd_go && (cmd_op == OP_XPAH) && (cmd_sel == gi)),
                .inc_i     ((gi == 0) && bus_start && (cmd_op == OP_FETCH)),
                .byte_i    (acc_reg),
                .ptr_o     (ptr_q[gi])
            );
        end
    endgenerate

    assign sel_ptr = ptr_q[cmd_sel];

    // Fetch uses the program counter after its increment
    always_comb
    begin
        bus_addr = sel_ptr;
        if (cmd_op == OP_FETCH)
            bus_addr = {ptr_q[0][15:12], ptr_q[0][11:0] + `SCB_PC_STEP};
    end

    // High address nibble and cycle status for the address strobe
    always_comb
    begin
        ads_byte = {4'h0, bus_addr[15:12]};
        ads_byte[`SCB_DB_RD]    = (cmd_op == OP_LOAD) || (cmd_op == OP_FETCH);
        ads_byte[`SCB_DB_FETCH] = (cmd_op == OP_FETCH);
        ads_byte[`SCB_DB_DELAY] = (cmd_op == OP_DELAY);
        ads_byte[`SCB_DB_HALT]  = (cmd_op == OP_HALT);
    end

    // --------------------------------------------------
    // Bus cycle sequencer
    // --------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg          <= ST_IDLE;
            cnt_reg            <= `SCB_RST_CNT;
            addr_o             <= `SCB_RST_ADDR;
            addr_hi_reg        <= `SCB_RST_NIB;
            data_o             <= `SCB_RST_BYTE;
            data_oe_o          <= 1'b0;
            read_strobe_n_o    <= 1'b1;
            write_strobe_n_o   <= 1'b1;
            address_strobe_n_o <= 1'b1;
            dma_grant_o        <= 1'b0;
            cyc_rd_reg         <= 1'b0;
            cyc_wr_reg         <= 1'b0;
            cyc_fetch_reg      <= 1'b0;
            cyc_mark_reg       <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (dma_req_i)
                    begin
                        // Release the data port for memory-to-peripheral transfer
                        state_reg   <= ST_DMA;
                        dma_grant_o <= 1'b1;
                    end
                    else if (bus_start)
                    begin
                        state_reg          <= ST_ADDR;
                        cnt_reg            <= `SCB_RST_CNT;
                        addr_o             <= bus_addr[11:0];
                        addr_hi_reg        <= bus_addr[15:12];
                        data_o             <= ads_byte;
                        data_oe_o          <= 1'b1;
                        address_strobe_n_o <= 1'b0;
                        cyc_rd_reg         <= (cmd_op == OP_LOAD) || (cmd_op == OP_FETCH);
                        cyc_wr_reg         <= (cmd_op == OP_STORE);
                        cyc_fetch_reg      <= (cmd_op == OP_FETCH);
                        cyc_mark_reg       <= (cmd_op == OP_HALT) || (cmd_op == OP_DELAY);
                    end
                end
                ST_ADDR:
                begin
                    cnt_reg <= cnt_reg + `SCB_CNT_ONE;
                    if (cnt_reg == `SCB_ADS_LAST)
                    begin
                        address_strobe_n_o <= 1'b1;
                        cnt_reg            <= `SCB_RST_CNT;
                        if (cyc_mark_reg)
                        begin
                            state_reg <= ST_IDLE;
                            data_oe_o <= 1'b0;
                        end
                        else if (cyc_wr_reg)
                        begin
                            state_reg        <= ST_STRB;
                            write_strobe_n_o <= 1'b0;
                            data_o           <= acc_reg;
                        end
                        else
                        begin
                            state_reg       <= ST_STRB;
                            read_strobe_n_o <= 1'b0;
                            data_oe_o       <= 1'b0;
                        end
                    end
                end
                ST_STRB:
                begin
                    cnt_reg <= cnt_reg + `SCB_CNT_ONE;
                    if (cnt_reg == `SCB_STB_LAST)
                    begin
                        state_reg        <= ST_IDLE;
                        cnt_reg          <= `SCB_RST_CNT;
                        read_strobe_n_o  <= 1'b1;
                        write_strobe_n_o <= 1'b1;
                        data_oe_o        <= 1'b0;
                    end
                end
                ST_DMA:
                begin
                    if (!dma_req_i)
                    begin
                        state_reg   <= ST_IDLE;
                        dma_grant_o <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------
    // Accumulator, the hub of all transfers except fetches, which land in insn_reg
    // --------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
            acc_reg <= `SCB_RST_BYTE;
        else if (rd_done && !cyc_fetch_reg)
            acc_reg <= data_i;
        else if (cmd_go)
        begin
            case (cmd_op)
                OP_XAE:  acc_reg <= ext_reg;
                OP_CSA:  acc_reg <= status_rd;
                OP_XPAL: acc_reg <= sel_ptr[7:0];
                OP_XPAH: acc_reg <= sel_ptr[15:8];
                OP_ADD:  acc_reg <= acc_reg + ext_reg;
                OP_AND:  acc_reg <= acc_reg & ext_reg;
                OP_OR:   acc_reg <= acc_reg | ext_reg;
                OP_XOR:  acc_reg <= acc_reg ^ ext_reg;
                default: acc_reg <= acc_reg;
            endcase
        end
        else if (wr_acc)
            acc_reg <= reg_wdata_i;
    end

    // Fetched byte lands in the instruction register
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
            insn_reg <= `SCB_RST_BYTE;
        else if (rd_done && cyc_fetch_reg)
            insn_reg <= data_i;
    end

    // --------------------------------------------------
    // Extension register and serial output latch
    // --------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            ext_reg  <= `SCB_RST_BYTE;
            sout_reg <= 1'b0;
        end
        else if (cmd_go && (cmd_op == OP_SHIFT))
        begin
            ext_reg  <= {serial_in_pin_i, ext_reg[7:1]};
            sout_reg <= ext_reg[0];
        end
        else if (cmd_go && (cmd_op == OP_XAE))
            ext_reg <= acc_reg;
        else if (wr_ext)
            ext_reg <= reg_wdata_i;
    end

    // --------------------------------------------------
    // Status register, flags and interrupt
    // --------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
            status_reg <= `SCB_RST_BYTE;
        else if (irq_div)
            status_reg[`SCB_ST_IE] <= 1'b0;
        else if (wr_stat || (cmd_go && (cmd_op == OP_CAS)))
            status_reg <= status_wr;
    end

    // Sticky interrupt mark, a new diversion beats a clear
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            irq_seen_reg  <= 1'b0;
            irq_pulse_reg <= 1'b0;
        end
        else
        begin
            irq_pulse_reg <= irq_div;
            if (irq_div)
                irq_seen_reg <= 1'b1;
            else if (wr_bus && reg_wdata_i[`SCB_BS_IRQ])
                irq_seen_reg <= 1'b0;
        end
    end

    assign flag_o       = status_reg[2:0];
    assign serial_out_o = sout_reg;
    assign irq_taken_o  = irq_pulse_reg;

    // --------------------------------------------------
    // Register read port
    // --------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i || !reg_rd_i)
            reg_rdata_o <= `SCB_RST_BYTE;
        else
        begin
            case (reg_addr_i)
                `SCB_OFF_ACC:  reg_rdata_o <= acc_reg;
                `SCB_OFF_EXT:  reg_rdata_o <= ext_reg;
                `SCB_OFF_STAT: reg_rdata_o <= status_rd;
                `SCB_OFF_BUS:  reg_rdata_o <= {4'h0, dma_grant_o, sout_reg,
                                               irq_seen_reg, state_reg != ST_IDLE};
                `SCB_OFF_INSN: reg_rdata_o <= insn_reg;
                default:       reg_rdata_o <= `SCB_RST_BYTE;
            endcase
        end
    end

    // --------------------------------------------------
    // Assertions
    // --------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    AST_ADS_BYTE: assert property (
        $fell(address_strobe_n_o) |-> data_oe_o && (data_o[3:0] == addr_hi_reg)
            && (data_o[`SCB_DB_FETCH] == cyc_fetch_reg))
        else $error("address strobe byte wrong");
    AST_ADS_LEN: assert property (
        $fell(address_strobe_n_o) |-> !address_strobe_n_o ##1 !address_strobe_n_o
            ##1 address_strobe_n_o)
        else $error("address strobe length wrong");
    AST_WR_DATA: assert property (
        $fell(write_strobe_n_o) |-> data_oe_o && (data_o == $past(acc_reg))
            ##1 (data_oe_o && $stable(data_o)) [*2])
        else $error("write data not held during strobe");
    AST_RD_FLOAT: assert property (
        !read_strobe_n_o |-> !data_oe_o && write_strobe_n_o && address_strobe_n_o)
        else $error("bus driven during read");
    AST_RD_CAPT: assert property (
        (rd_done && !cyc_fetch_reg) |=> (acc_reg == $past(data_i)) && read_strobe_n_o)
        else $error("read data not captured");
    AST_ADDR_HOLD: assert property (
        (state_reg != ST_IDLE && state_reg != ST_DMA && $past(state_reg) != ST_IDLE)
            |-> $stable(addr_o))
        else $error("address moved in cycle");
    AST_FLAGS: assert property (
        wr_stat |=> (flag_o == $past(reg_wdata_i[2:0])))
        else $error("flags do not follow status");
    AST_SHIFT: assert property (
        (cmd_go && cmd_op == OP_SHIFT) |=>
            (ext_reg == {$past(serial_in_pin_i), $past(ext_reg[7:1])})
            && (serial_out_o == $past(ext_reg[0])))
        else $error("serial shift wrong");
    AST_IRQ: assert property (
        irq_div |=> irq_taken_o && !status_reg[`SCB_ST_IE] && (state_reg == ST_IDLE)
            ##1 !irq_taken_o)
        else $error("interrupt not diverted");
    AST_SENSE: assert property (
        (reg_rd_i && reg_addr_i == `SCB_OFF_STAT) |=>
            (reg_rdata_o[`SCB_ST_SB:`SCB_ST_SA] == $past({sense_b_i, sense_a_i})))
        else $error("sense bits not read back");
    AST_DMA: assert property (
        dma_grant_o |-> !data_oe_o && address_strobe_n_o && read_strobe_n_o
            && write_strobe_n_o)
        else $error("bus driven during dma");

    COV_LOAD:  cover property ($rose(read_strobe_n_o) && !cyc_fetch_reg);
    COV_STORE: cover property ($rose(write_strobe_n_o));
    COV_IRQ:   cover property (irq_taken_o);
    COV_DMA:   cover property ($fell(dma_grant_o));
endmodule // scb_bus_io
`default_nettype wire

/* verif/scb_mem_model.sv */
// Memory on the far side of the external bus
`timescale 1ns/1ps
`default_nettype none
module scb_mem_model (
    input  wire logic        mclk_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  bus_i,
    input  wire logic        bus_oe_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        as_n_i,
    output logic      [7:0]  data_o
);
    logic [7:0] mem [0:65535];
    logic [3:0] hi_reg;
    logic [7:0] last_reg = 8'hA5;
    always @(posedge mclk_i)
    begin
        if (!as_n_i && bus_oe_i) hi_reg <= bus_i[3:0];
        if (!wr_n_i && bus_oe_i) mem[{hi_reg, addr_i}] <= bus_i;
        if (!rd_n_i) last_reg <= data_o;
    end
    // Released bus shows the inverse of the last byte
    assign data_o = !rd_n_i ? mem[{hi_reg, addr_i}] : ~last_reg;
endmodule // scb_mem_model
`default_nettype wire

/* verif/tb_top.sv */
// Testbench for the bus and I/O unit
`timescale 1ns/1ps
`default_nettype none
`include "scb_map.svh"
`define CHK(a,b) begin compares++; if ((a)!==(b)) begin num_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    import scb_pkg::*;
    typedef struct {logic [7:0] acc; logic [7:0] ext; scb_op_t op; logic [7:0] res;} scb_row_t;
    logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, dma_req_i, sense_a_i, sense_b_i;
    logic serial_in_pin_i, data_oe_o, dma_grant_o, serial_out_o, irq_taken_o;
    logic read_strobe_n_o, write_strobe_n_o, address_strobe_n_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, data_i, data_o, d;
    logic [11:0] addr_o;
    logic [2:0] flag_o;
    int num_errors = 0, compares = 0, irqs = 0;
    logic [15:0] exp_a = 16'hA234;
    scb_row_t rows [5] = '{'{8'h0F, 8'h3C, OP_ADD, 8'h4B}, '{8'h0F, 8'h3C, OP_AND, 8'h0C},
        '{8'h0F, 8'h3C, OP_OR, 8'h3F}, '{8'h0F, 8'h3C, OP_XOR, 8'h33},
        '{8'h0F, 8'h3C, OP_XAE, 8'h3C}};
    scb_bus_io scb_bus_io_i (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .addr_o, .data_i, .data_o, .data_oe_o, .read_strobe_n_o,
        .write_strobe_n_o, .address_strobe_n_o, .dma_req_i, .dma_grant_o, .sense_a_i,
        .sense_b_i, .serial_in_pin_i, .serial_out_o, .flag_o, .irq_taken_o);
    scb_mem_model scb_mem_model_i (.mclk_i, .addr_i(addr_o), .bus_i(data_o),
        .bus_oe_i(data_oe_o), .rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_n_o),
        .as_n_i(address_strobe_n_o), .data_o(data_i));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // Issue a command and poll busy until it clears
    task automatic cmd(input logic [1:0] p, input scb_op_t op);
        wr(`SCB_OFF_CMD, {2'b00, p, op});
        for (int i = 0; i < 20; i++)
        begin
            rd(`SCB_OFF_BUS);
            if (d[`SCB_BS_BUSY] === 1'b0) break;
        end
        `CHK(d[`SCB_BS_BUSY], 1'b0)
    endtask
    task automatic end_of_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial
    begin
        #100000;
        num_errors++;
        end_of_test;
    end
    // Pin watch during bus cycles, aimed at the expected address
    always @(negedge mclk_i)
    begin
        if (irq_taken_o === 1'b1) irqs++;
        if (address_strobe_n_o === 1'b0) `CHK(data_o[3:0], exp_a[15:12])
        if (!(read_strobe_n_o && write_strobe_n_o)) `CHK(addr_o, exp_a[11:0])
        if (read_strobe_n_o === 1'b0) `CHK(data_oe_o, 1'b0)
        if (write_strobe_n_o === 1'b0) `CHK(data_o, 8'h5C)
    end
    initial
    begin
        {sys_rst_i, reg_wr_i, reg_rd_i, dma_req_i, sense_a_i, sense_b_i} = 6'h20;
        {reg_addr_i, reg_wdata_i, serial_in_pin_i} = 17'h00000;
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1 `CHK({flag_o, serial_out_o}, 4'h0)
        foreach (rows[i])
        begin
            wr(`SCB_OFF_ACC, rows[i].acc);
            wr(`SCB_OFF_EXT, rows[i].ext);
            cmd(2'b00, rows[i].op);
            rd(`SCB_OFF_ACC);
            `CHK(d, rows[i].res)
        end
        rd(`SCB_OFF_EXT);
        `CHK(d, 8'h0F)
        $display("alu rows done");
        for (int f = 0; f < 8; f++)
        begin
            wr(`SCB_OFF_STAT, f[7:0]);
            @(posedge mclk_i);
            #1 `CHK(flag_o, f[2:0])
        end
        wr(`SCB_OFF_ACC, 8'h06);
        cmd(2'b00, OP_CAS);
        `CHK(flag_o, 3'b110)
        @(posedge mclk_i);
        sense_b_i <= 1'b1;
        cmd(2'b00, OP_CSA);
        rd(`SCB_OFF_ACC);
        `CHK(d, 8'h26)
        for (int s = 0; s < 4; s++)
        begin
            @(posedge mclk_i);
            {sense_b_i, sense_a_i} <= s[1:0];
            rd(`SCB_OFF_STAT);
            `CHK(d[`SCB_ST_SA], s[0])
            `CHK(d[`SCB_ST_SB], s[1])
        end
        $display("flag and sense done");
        wr(`SCB_OFF_EXT, 8'h81);
        cmd(2'b00, OP_SHIFT);
        rd(`SCB_OFF_EXT);
        `CHK(d, 8'h40)
        `CHK(serial_out_o, 1'b1)
        @(posedge mclk_i);
        serial_in_pin_i <= 1'b1;
        cmd(2'b00, OP_SHIFT);
        rd(`SCB_OFF_EXT);
        `CHK({d, serial_out_o}, 9'h140)
        $display("shift done");
        wr(`SCB_OFF_ACC, 8'h34);
        cmd(2'b01, OP_XPAL);
        wr(`SCB_OFF_ACC, 8'hA2);
        cmd(2'b01, OP_XPAH);
        wr(`SCB_OFF_ACC, 8'h5C);
        cmd(2'b01, OP_STORE);
        `CHK(scb_mem_model_i.mem[16'hA234], 8'h5C)
        wr(`SCB_OFF_ACC, 8'h00);
        cmd(2'b01, OP_LOAD);
        rd(`SCB_OFF_ACC);
        `CHK(d, 8'h5C)
        wr(`SCB_OFF_ACC, 8'h77);
        cmd(2'b01, OP_XPAL);
        rd(`SCB_OFF_ACC);
        `CHK(d, 8'h34)
        $display("memory done");
        wr(`SCB_OFF_STAT, 8'h08);
        cmd(2'b00, OP_FETCH);
        `CHK(irqs, 1)
        rd(`SCB_OFF_STAT);
        `CHK(d[`SCB_ST_IE], 1'b0)
        rd(`SCB_OFF_BUS);
        `CHK(d[`SCB_BS_IRQ], 1'b1)
        wr(`SCB_OFF_BUS, 8'h02);
        rd(`SCB_OFF_BUS);
        `CHK(d[`SCB_BS_IRQ], 1'b0)
        $display("interrupt done");
        @(posedge mclk_i);
        sense_a_i <= 1'b0;
        scb_mem_model_i.mem[16'h0001] = 8'h3C;
        exp_a = 16'h0001;
        wr(`SCB_OFF_STAT, 8'h08);
        cmd(2'b00, OP_FETCH);
        `CHK(irqs, 1)
        rd(`SCB_OFF_INSN);
        `CHK(d, 8'h3C)
        $display("fetch done");
        @(posedge mclk_i);
        dma_req_i <= 1'b1;
        @(posedge mclk_i);
        #1 `CHK({dma_grant_o, data_oe_o}, 2'b10)
        @(posedge mclk_i);
        dma_req_i <= 1'b0;
        @(posedge mclk_i);
        #1 `CHK(dma_grant_o, 1'b0)
        $display("dma done");
        wr(`SCB_OFF_STAT, 8'h07);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1 `CHK({flag_o, serial_out_o}, 4'h0)
        $display("reset done");
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
